// file: verif/pin_source.sv
// Purpose: far side of the capture bank: watched pins and a running precision time
// Assumes: pins and time change just after a rising clk_sys edge
// Notes: time is a pure function of a cycle count, so every stamp is predictable
`timescale 1ns/100ps
`default_nettype none

module pin_source
  import capture_unit_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // pins and time
  output logic [11:0] gpioIn,
  output ptp_time_t ptpTime
);
  logic [31:0] cycleCnt = 32'h0;
  int seed = 76;

  initial
  begin
    gpioIn = 12'h000;
    ptpTime = '0;
  end

  //////////////////////////////////////////////////////////////
  // one 8 ns step a cycle; sub code walks 0..4 so it never needs clamping
  always @(posedge clk_sys)
  begin
    cycleCnt <= rst_n ? cycleCnt + 32'h1 : 32'h0;
    ptpTime <= '{cycleCnt + 32'h1, (cycleCnt + 32'h1) * 32'h8, 3'((cycleCnt + 32'h1) % 5)};
  end

  // one pin change after an edge; returns the seconds value shown with it
  task automatic setPin(input int pin, input logic level, output logic [31:0] stamp);
    @(posedge clk_sys);
    stamp = cycleCnt + 32'h1;
    gpioIn[pin] <= level;
  endtask

  // random spacing between edges, never below two cycles
  task automatic gap();
    repeat (2 + ($random(seed) & 3)) @(posedge clk_sys);
  endtask
endmodule

`default_nettype wire

// file: verif/tb_top.sv
// Purpose: self-checking bench for the capture bank
// Assumes: zero-wait APB slave, capture one edge after the pin change
// Notes: expected reads are queued by the driver and checked by a monitor
`timescale 1ns/100ps
`default_nettype none

module tb_top
  import capture_unit_pkg::*;
;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic irq;
  logic [11:0] gpioIn;
  ptp_time_t ptpTime;
  logic [32:0] expQ[$];
  logic [32:0] note;
  logic [31:0] ts[0:17];
  int error_cnt = 0;
  int check_count = 0;
  int seed = 76;
  int p;

  initial
    forever #4 clk_sys = ~clk_sys;

  capture_units i_dut (.clk_sys(clk_sys), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .gpioIn(gpioIn), .ptpTime(ptpTime), .irq(irq));

  pin_source i_pins (.clk_sys(clk_sys), .rst_n(rst_n), .gpioIn(gpioIn), .ptpTime(ptpTime));

  //////////////////////////////////////////////////////////////
  task automatic cmp(input logic [32:0] exp, input logic [32:0] got);
    check_count++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("CHECK FAILED t=%0t exp=%h got=%h", $time, exp, got);
    end
  endtask

  // request held until pready is seen high at an edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do @(posedge clk_sys); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] d, input logic err);
    expQ.push_back({err, err ? 32'h0 : d});
    apb(1'b0, a, 32'h0);
  endtask

  // seconds, nanoseconds and sub code of one slot
  task automatic smp(input int slot, input logic [31:0] s);
    rd(OFF_SAMPLE + 12'(16 * slot), s, 1'b0);
    rd(OFF_SAMPLE + 12'(16 * slot + 4), s * 32'h8, 1'b0);
    rd(OFF_SAMPLE + 12'(16 * slot + 8), s % 5, 1'b0);
  endtask

  // irq settles one edge after the capture edge
  task automatic chkIrq(input logic v);
    repeat (3) @(posedge clk_sys);
    cmp({32'h0, v}, {32'h0, irq});
  endtask

  // alternating edges starting with a rise
  task automatic edges(input int pin, input int n);
    for (int k = 0; k < n; k++)
    begin
      i_pins.gap();
      i_pins.setPin(pin, ~k[0], ts[k]);
    end
  endtask

  task automatic conclude();
    $display("errors=%0d checks=%0d", error_cnt, check_count);
    if (error_cnt == 0 && check_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  //////////////////////////////////////////////////////////////
  // read monitor takes the oldest note
  always @(posedge clk_sys)
    if (psel && penable && pready === 1'b1 && !pwrite)
    begin
      note = expQ.pop_front();
      cmp(note, {pslverr, prdata});
    end

  initial
  begin
    #160000;
    error_cnt++;
    conclude();
  end

  initial
  begin
    repeat (5) @(posedge clk_sys);
    rst_n <= 1'b1;
    rd(OFF_UNIT_ENABLE, 32'h0, 1'b0);
    rd(OFF_INT_ENABLE, 32'h0, 1'b0);
    rd(OFF_STATUS, 32'h0, 1'b0);
    for (int u = 0; u < NUM_UNITS; u++)
      rd(OFF_CONFIG + 12'(4 * u), CFG_RESET, 1'b0);
    rd(12'h00C, 32'h0, 1'b1);
    rd(OFF_SAMPLE + 12'h00C, 32'h0, 1'b1);
    wr(OFF_CONFIG, 32'hFFFF_FFFF);
    rd(OFF_CONFIG, 32'h0000_0FC1, 1'b0);
    // rise only; edges before enabling are lost, a full unit keeps its pair
    p = ($random(seed) & 32'h7FFF_FFFF) % 4;
    wr(OFF_CONFIG, 32'h80 | 32'(p << 8));
    wr(OFF_INT_ENABLE, 32'h1);
    edges(p, 2);
    rd(OFF_STATUS, 32'h0, 1'b0);
    wr(OFF_UNIT_ENABLE, 32'h1);
    edges(p, 6);
    chkIrq(1'b1);
    smp(0, ts[0]);
    smp(1, ts[2]);
    rd(OFF_STATUS, 32'h1, 1'b0);
    wr(OFF_INT_ENABLE, 32'h0);
    chkIrq(1'b0);
    wr(OFF_STATUS, 32'h1);
    // both edges: a pulse lands in sample one and two, no interrupt enabled
    p = 4 + ($random(seed) & 3);
    wr(OFF_CONFIG + 12'h004, 32'hC0 | 32'(p << 8));
    wr(OFF_UNIT_ENABLE, 32'h2);
    // an even count leaves the pin low, so the chain below starts on a real rise
    edges(p, 4);
    smp(2, ts[0]);
    smp(3, ts[1]);
    rd(OFF_STATUS, 32'h2, 1'b0);
    chkIrq(1'b0);
    // chain of two units on one pin
    wr(OFF_CONFIG + 12'h008, 32'h81 | 32'(p << 8));
    wr(OFF_CONFIG + 12'h00C, 32'h80);
    wr(OFF_UNIT_ENABLE, 32'hC);
    edges(p, 8);
    for (int s = 0; s < 4; s++)
      rd(OFF_SAMPLE + 12'(16 * (4 + s)), ts[2 * s], 1'b0);
    // fall only on unit 0: the rise is ignored, the fall lands in sample one
    wr(OFF_CONFIG, 32'h40 | 32'(p << 8));
    wr(OFF_UNIT_ENABLE, 32'h1);
    edges(p, 2);
    smp(0, ts[1]);
    // flags stay set after their units are disabled
    rd(OFF_STATUS, 32'hF, 1'b0);
    // eight-sample unit drops the ninth rise
    p = 8 + ($random(seed) & 3);
    wr(OFF_CONFIG + 12'h02C, 32'h80 | 32'(p << 8));
    wr(OFF_INT_ENABLE, 32'h800);
    wr(OFF_UNIT_ENABLE, 32'h800);
    edges(p, 18);
    chkIrq(1'b1);
    for (int s = 0; s < 8; s++)
      rd(OFF_SAMPLE + 12'(16 * (22 + s)), ts[2 * s], 1'b0);
    conclude();
  end
endmodule

`default_nettype wire

// file: verilog/capture_unit_pkg.sv
// Purpose: constants, types and helpers for the edge timestamp capture bank
// Assumes: 32-bit APB, byte addresses, one register per aligned word
// Notes: sample slots of all units live in one flat array
//
// Function
// - There are twelve independent capture units, each watching a pin that software picks.
// - A selected edge latches the present precision time as that edge's timestamp.
// - An ordinary unit holds two samples and, once full, keeps them until software frees them.
// - Each sample holds seconds, nanoseconds and a sub-nanosecond code in separate registers.
// - The sub-nanosecond code is a value from zero to four meaning 0, 8, 16, 24 or 32 ns.
// - The last unit holds eight samples instead of two, each with its own time registers.
// - Cascaded units take the shared pin's events one after another in chain order.
// - With a single edge selected, the first timestamp lands in the first sample.
// - With both edges selected, a pulse puts one edge in sample one and the other in sample two.
// - Configuration bit 6 enables timestamps of falling edges.
// - Configuration bit 7 enables timestamps of rising edges.
// - Configuration bits 11 to 8 select the monitored pin.
// - Each unit has its own interrupt enable bit in a shared enable register.
// - A unit works only once its bit in the shared unit enable register is set.
package capture_unit_pkg;

  localparam int NUM_UNITS = 12;
  localparam int NUM_SLOTS = 30;
  localparam int BIG_UNIT = 11;
  localparam logic [3:0] SMALL_DEPTH = 4'h2;
  localparam logic [3:0] BIG_DEPTH = 4'h8;
  localparam logic [4:0] BIG_BASE = 5'h16;

  // register byte offsets
  localparam logic [11:0] OFF_UNIT_ENABLE = 12'h000;
  localparam logic [11:0] OFF_INT_ENABLE = 12'h004;
  localparam logic [11:0] OFF_STATUS = 12'h008;
  localparam logic [11:0] OFF_CONFIG = 12'h040;
  localparam logic [11:0] OFF_CONFIG_END = 12'h070;
  localparam logic [11:0] OFF_SAMPLE = 12'h100;
  localparam logic [11:0] OFF_SAMPLE_END = 12'h2E0;

  // configuration fields
  localparam int CFG_CASCADE_BIT = 0;
  localparam int CFG_FALL_BIT = 6;
  localparam int CFG_RISE_BIT = 7;
  localparam int CFG_PIN_LSB = 8;
  localparam logic [31:0] CFG_WRITE_MASK = 32'h0000_0FC1;
  localparam logic [31:0] CFG_RESET = 32'h0000_0000;
  localparam logic [11:0] VEC_RESET = 12'h000;

  // sub-nanosecond code, one step of the 125 MHz clock
  localparam logic [2:0] SUB_MAX = 3'h4;
  localparam int SUB_STEP_NS = 8;

  typedef struct packed {
    logic [31:0] sec;
    logic [31:0] ns;
    logic [2:0] sub;
  } ptp_time_t;

  // first flat slot of a unit
  function automatic logic [4:0] slotBase(input int u);
    slotBase = (u == BIG_UNIT) ? BIG_BASE : 5'(u * 2);
  endfunction

  // samples a unit can hold
  function automatic logic [3:0] unitDepth(input int u);
    unitDepth = (u == BIG_UNIT) ? BIG_DEPTH : SMALL_DEPTH;
  endfunction

endpackage

// file: verilog/capture_units.sv
// Purpose: twelve edge timestamp capture units behind an APB slave
// Assumes: pins and time inputs synchronous to clk_sys
// Notes: clearing a status bit frees that unit's samples
`timescale 1ns/100ps
`default_nettype none

module capture_units
  import capture_unit_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // watched pins and precision time
  input wire logic [11:0] gpioIn,
  input wire ptp_time_t ptpTime,
  // interrupt
  output logic irq
);

  ////////////////////////////////////////////////////////////////////////////
  // state

  logic [11:0] unitEnable;
  logic [11:0] intEnable;
  logic [11:0] capStatus;
  logic [31:0] cfgReg [NUM_UNITS];
  logic [3:0] fill [NUM_UNITS];
  ptp_time_t smp [NUM_SLOTS];
  logic [11:0] gpioPrev;

  ////////////////////////////////////////////////////////////////////////////
  // apb decode

  wire apbSetup = psel & ~penable;
  wire apbWrite = psel & penable & pready & pwrite;
  wire aligned = (paddr[1:0] == 2'h0);
  wire selEnable = aligned & (paddr == OFF_UNIT_ENABLE);
  wire selIe = aligned & (paddr == OFF_INT_ENABLE);
  wire selStatus = aligned & (paddr == OFF_STATUS);
  wire selConfig = aligned & (paddr >= OFF_CONFIG) & (paddr < OFF_CONFIG_END);
  wire [3:0] cfgIdx = paddr[5:2];
  // last word of each sample group is a hole
  wire selSample = aligned & (paddr >= OFF_SAMPLE) & (paddr < OFF_SAMPLE_END)
    & (paddr[3:2] != 2'h3);
  wire [4:0] sIdx = 5'(paddr[9:4] - 6'h10);
  wire [1:0] sField = paddr[3:2];
  wire mapped = selEnable | selIe | selStatus | selConfig | selSample;
  wire [11:0] stsClear = (apbWrite & selStatus) ? pwdata[11:0] : VEC_RESET;

  // clamp keeps the code in its legal range
  wire [2:0] subNow = (ptpTime.sub > SUB_MAX) ? SUB_MAX : ptpTime.sub;
  wire ptp_time_t timeNow = '{sec: ptpTime.sec, ns: ptpTime.ns, sub: subNow};

  // read data selection
  wire ptp_time_t rdSmp = smp[sIdx];
  wire [31:0] rdSample = (sField == 2'h0) ? rdSmp.sec :
    (sField == 2'h1) ? rdSmp.ns : {29'h0, rdSmp.sub};
  wire [31:0] readWord = selEnable ? {20'h0, unitEnable} :
    selIe ? {20'h0, intEnable} :
    selStatus ? {20'h0, capStatus} :
    selConfig ? cfgReg[cfgIdx] :
    selSample ? rdSample : 32'h0;

  ////////////////////////////////////////////////////////////////////////////
  // per-unit edge detection

  logic [11:0] cfgRise;
  logic [11:0] cfgFall;
  logic [11:0] cfgCascade;
  logic [11:0] riseSel;
  logic [11:0] fallSel;
  logic [11:0] isFollower;
  logic [11:0] full;
  logic [11:0] unitEvent;

  // a unit fed by its predecessor's chain ignores its own pin
  always_comb
  begin
    for (int u = 0; u < NUM_UNITS; u++)
    begin
      logic [3:0] pin;
      pin = cfgReg[u][CFG_PIN_LSB +: 4];
      cfgRise[u] = cfgReg[u][CFG_RISE_BIT];
      cfgFall[u] = cfgReg[u][CFG_FALL_BIT];
      cfgCascade[u] = cfgReg[u][CFG_CASCADE_BIT];
      riseSel[u] = (pin < 4'hC) && gpioIn[pin] && !gpioPrev[pin];
      fallSel[u] = (pin < 4'hC) && !gpioIn[pin] && gpioPrev[pin];
      isFollower[u] = cfgReg[(u + NUM_UNITS - 1) % NUM_UNITS][CFG_CASCADE_BIT];
      full[u] = (fill[u] >= unitDepth(u));
      unitEvent[u] = unitEnable[u] && !isFollower[u]
        && ((cfgRise[u] && riseSel[u]) || (cfgFall[u] && fallSel[u]));
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // routing of events to the unit that stores them

  logic [11:0] capHit;

  // walk the chain from the head until an enabled unit with room is found
  always_comb
  begin
    int t;
    logic done;
    t = 0;
    done = 1'b0;
    capHit = VEC_RESET;
    for (int h = 0; h < NUM_UNITS; h++)
    begin
      t = h;
      done = !unitEvent[h];
      for (int k = 0; k < NUM_UNITS; k++)
      begin
        if (!done)
        begin
          if (!full[t] && unitEnable[t])
          begin
            capHit[t] = 1'b1;
            done = 1'b1;
          end
          else if (cfgCascade[t])
            t = (t == NUM_UNITS - 1) ? 0 : t + 1;
          else
            done = 1'b1;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // apb registers

  // answer comes in the access phase, no wait states
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0;
    end
    else
    begin
      pready <= apbSetup;
      pslverr <= apbSetup & ~mapped;
      prdata <= (apbSetup & ~pwrite) ? readWord : 32'h0;
    end
  end

  // software control registers
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      unitEnable <= VEC_RESET;
      intEnable <= VEC_RESET;
      for (int u = 0; u < NUM_UNITS; u++)
        cfgReg[u] <= CFG_RESET;
    end
    else if (apbWrite)
    begin
      if (selEnable)
        unitEnable <= pwdata[11:0];
      if (selIe)
        intEnable <= pwdata[11:0];
      if (selConfig)
        cfgReg[cfgIdx] <= pwdata & CFG_WRITE_MASK;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // capture, status and interrupt

  // set wins over clear; clearing frees the unit so a capture restarts at slot one
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      capStatus <= VEC_RESET;
      gpioPrev <= VEC_RESET;
      irq <= 1'b0;
      for (int u = 0; u < NUM_UNITS; u++)
        fill[u] <= 4'h0;
    end
    else
    begin
      gpioPrev <= gpioIn;
      capStatus <= (capStatus & ~stsClear) | capHit;
      irq <= |(capStatus & intEnable);
      for (int u = 0; u < NUM_UNITS; u++)
        if (stsClear[u])
          fill[u] <= {3'h0, capHit[u]};
        else if (capHit[u])
          fill[u] <= fill[u] + 4'h1;
    end
  end

  // sample storage has no reset; it is only meaningful once filled
  always_ff @(posedge clk_sys)
  begin
    for (int u = 0; u < NUM_UNITS; u++)
      if (capHit[u])
        smp[slotBase(u) + (stsClear[u] ? 5'h0 : {1'b0, fill[u]})] <= timeNow;
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);

  // helpers read only by the checks
  wire irqCause = |(capStatus & intEnable);
  logic subOk;
  logic fillOk;
  always_comb
  begin
    subOk = 1'b1;
    fillOk = 1'b1;
    for (int s = 0; s < NUM_SLOTS; s++)
      if (smp[s].sub > SUB_MAX)
        subOk = 1'b0;
    for (int u = 0; u < NUM_UNITS; u++)
      if (fill[u] > unitDepth(u))
        fillOk = 1'b0;
  end

  sequence firstCap0;
    capHit[0] && (fill[0] == 4'h0) && !stsClear[0];
  endsequence

  sequence secondCap0;
    capHit[0] && (fill[0] == 4'h1) && !stsClear[0];
  endsequence

  a_first_sample: assert property (firstCap0 |=> smp[0] == $past(timeNow))
    else $error("first capture not in sample one");

  a_second_sample: assert property (secondCap0 |=> smp[1] == $past(timeNow))
    else $error("second capture not in sample two");

  a_full_hold: assert property (full[0] && !stsClear[0] |=> $stable(smp[0]) && $stable(smp[1]))
    else $error("full unit overwritten");

  a_big_depth: assert property (capHit[11] && fill[11] == 4'h7 && !stsClear[11]
    |=> full[11] && fill[11] == BIG_DEPTH)
    else $error("eight sample unit depth wrong");

  a_fill_bound: assert property (fillOk)
    else $error("unit fill beyond depth");

  a_sub_range: assert property (subOk)
    else $error("sub code above four");

  a_enable_gate: assert property ((capHit & ~unitEnable) == VEC_RESET)
    else $error("capture in disabled unit");

  a_fall_edge: assert property (unitEvent[0] && !cfgRise[0] |-> fallSel[0] && cfgFall[0])
    else $error("falling capture without falling edge");

  a_rise_edge: assert property (unitEvent[0] && !cfgFall[0] |-> riseSel[0] && cfgRise[0])
    else $error("rising capture without rising edge");

  a_cascade_hand: assert property (capHit[3] && !unitEvent[3] |-> cfgCascade[2] && full[2])
    else $error("cascade handed event out of order");

  a_status_set: assert property (capHit[3] |=> capStatus[3] ##1 capStatus[3] || $past(stsClear[3]))
    else $error("status flag not set by capture");

  a_irq_level: assert property (irqCause |=> irq)
    else $error("interrupt missing");

  a_irq_gated: assert property (!irqCause |=> !irq)
    else $error("interrupt without enabled status");

endmodule

`default_nettype wire
